// *** logic/fpc_pkg.sv ***
// Purpose: constants for the front-panel mode and display control block
// Assumes: 50 MHz system clock
// Notes: all buttons arrive as clean synchronous levels, active high
package fpc_pkg;

    // ========================================================
    // timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned LONG_HOLD_S   = 5;
    localparam int unsigned SHORT_HOLD_S  = 1;
    localparam int unsigned SUSPEND_MIN   = 2;
    localparam int unsigned LONG_HOLD_CYC  = LONG_HOLD_S * CLK_HZ;
    localparam int unsigned SHORT_HOLD_CYC = SHORT_HOLD_S * CLK_HZ;
    localparam longint unsigned SUSPEND_CYC =
        64'(SUSPEND_MIN) * 64'd60 * 64'(CLK_HZ);
    localparam int unsigned TICK_CYC      = CLK_HZ;

    // ========================================================
    // operating modes
    typedef enum logic [2:0]
    {
        FPC_OFF    = 3'b000,
        FPC_MANUAL = 3'b001,
        FPC_AUTO   = 3'b010,
        FPC_TEST   = 3'b011
    } fpc_mode_e;

    // ========================================================
    // display defaults
    localparam logic [3:0] ALARM_GROUP = 4'h8;
    localparam logic [3:0] GROUP_RST   = 4'h0;
    localparam logic [3:0] SCREEN_RST  = 4'h0;

endpackage

// *** logic/fpc_hold_timer.sv ***
// Purpose: long-press detector, one pulse after a continuous hold
// Assumes: i_hold is a synchronous level
// Notes: counter restarts whenever the hold drops
`timescale 1ns/1ns
module fpc_hold_timer
#(
    parameter int unsigned HOLD_CYC = 32'd250000000
)
(
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_hold,
    output logic      o_fire
);

    logic [31:0] cnt_q;
    logic        done_q;

    // ========================================================
    // hold counter
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cnt_q  <= 32'h0;
            done_q <= 1'b0;
            o_fire <= 1'b0;
        end
        else if (!i_hold)
        begin
            cnt_q  <= 32'h0;
            done_q <= 1'b0;
            o_fire <= 1'b0;
        end
        else if (!done_q && cnt_q == HOLD_CYC - 32'd1)
        begin
            done_q <= 1'b1;
            o_fire <= 1'b1;
        end
        else
        begin
            o_fire <= 1'b0;
            if (!done_q)
                cnt_q <= cnt_q + 32'd1;
        end
    end

endmodule

// *** logic/fpc_front_panel.sv ***
// Purpose: front-panel buttons to modes, contactors, display and lamps
// Assumes: buttons are debounced synchronous levels, active high
// Notes: long counts are parameters so simulation can shorten them
`timescale 1ns/1ns
module fpc_front_panel
#(
    parameter int unsigned LONG_CYC   = fpc_pkg::LONG_HOLD_CYC,
    parameter int unsigned SHORT_CYC  = fpc_pkg::SHORT_HOLD_CYC,
    parameter longint unsigned SUSP_CYC = fpc_pkg::SUSPEND_CYC,
    parameter int unsigned TICK_CYC   = fpc_pkg::TICK_CYC,
    parameter int unsigned NUM_GROUPS = 12,
    parameter int unsigned NUM_SCREENS = 8
)
(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_btn_test,
    input  wire logic       i_btn_manual,
    input  wire logic       i_btn_run,
    input  wire logic       i_btn_auto,
    input  wire logic       i_btn_off,
    input  wire logic       i_btn_next_scr,
    input  wire logic       i_btn_prev_scr,
    input  wire logic       i_btn_next_grp,
    input  wire logic       i_btn_prev_grp,
    input  wire logic       i_btn_mains_ctc,
    input  wire logic       i_btn_gen_ctc,
    input  wire logic       i_combo_program,
    input  wire logic       i_combo_service,
    input  wire logic       i_combo_adjust,
    input  wire logic       i_hold_loop_grp,
    input  wire logic       i_hold_annunc,
    input  wire logic       i_hold_selftune,
    input  wire logic       i_annunc_enable,
    input  wire logic [7:0] i_scroll_secs,
    input  wire logic [3:0] i_screens_in_grp,
    input  wire logic       i_fault,
    input  wire logic       i_start_blocked,
    input  wire logic       i_shutdown_alarm,
    input  wire logic       i_load_dump,
    input  wire logic       i_mains_ok,
    input  wire logic       i_remote_start_cfg,
    input  wire logic       i_remote_start,
    input  wire logic       i_simulate_mains,
    input  wire logic       i_mains_absence_override,
    input  wire logic       i_start_demand,
    output logic [2:0]      o_mode,
    output logic            o_engine_run,
    output logic            o_gen_load,
    output logic            o_cooldown,
    output logic            o_mains_ctc,
    output logic            o_gen_ctc,
    output logic            o_alarm_relay,
    output logic            o_program_mode,
    output logic            o_service_clear,
    output logic            o_hand_tuning_mode,
    output logic [1:0]      o_tuning_group,
    output logic            o_annunc_mode,
    output logic            o_self_tuning_mode,
    output logic [3:0]      o_group,
    output logic [3:0]      o_screen,
    output logic            o_lamp_test,
    output logic            o_led_auto_ready,
    output logic            o_led_alarm,
    output logic            o_led_mains_avail
);

    logic [31:0] edges_q;
    logic [31:0] prs;
    logic        any_press;
    logic        run_req_q;
    logic        stop_now_q;
    logic        fault_q;
    logic        fire_prog;
    logic        fire_serv;
    logic        fire_adj;
    logic        fire_loop;
    logic        fire_ann;
    logic        fire_self;
    logic [32:0] susp_q;
    logic [31:0] tick_q;
    logic [7:0]  secs_q;
    logic [3:0]  last_scr;

    // ========================================================
    // press edges
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            edges_q <= 32'h0;
        else
            edges_q <= {21'h0, i_btn_test, i_btn_manual, i_btn_run,
                        i_btn_auto, i_btn_off, i_btn_next_scr,
                        i_btn_prev_scr, i_btn_next_grp, i_btn_prev_grp,
                        i_btn_mains_ctc, i_btn_gen_ctc};
    end

    assign prs = {21'h0, i_btn_test, i_btn_manual, i_btn_run,
                  i_btn_auto, i_btn_off, i_btn_next_scr,
                  i_btn_prev_scr, i_btn_next_grp, i_btn_prev_grp,
                  i_btn_mains_ctc, i_btn_gen_ctc} & ~edges_q;
    assign any_press = |prs;

    // ========================================================
    // long-press timers
    fpc_hold_timer #(.HOLD_CYC(LONG_CYC)) u_prog
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_combo_program),
        .o_fire    (fire_prog)
    );
    fpc_hold_timer #(.HOLD_CYC(LONG_CYC)) u_serv
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_combo_service),
        .o_fire    (fire_serv)
    );
    fpc_hold_timer #(.HOLD_CYC(LONG_CYC)) u_adj
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_combo_adjust),
        .o_fire    (fire_adj)
    );
    fpc_hold_timer #(.HOLD_CYC(SHORT_CYC)) u_loop
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_hold_loop_grp),
        .o_fire    (fire_loop)
    );
    fpc_hold_timer #(.HOLD_CYC(LONG_CYC)) u_ann
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_hold_annunc),
        .o_fire    (fire_ann)
    );
    fpc_hold_timer #(.HOLD_CYC(LONG_CYC)) u_self
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_hold    (i_hold_selftune),
        .o_fire    (fire_self)
    );

    // ========================================================
    // operating mode and engine control
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_mode     <= fpc_pkg::FPC_OFF;
            run_req_q  <= 1'b0;
            stop_now_q <= 1'b0;
        end
        else if (prs[10])
        begin
            o_mode     <= fpc_pkg::FPC_TEST;
            stop_now_q <= 1'b0;
        end
        else if (prs[9])
        begin
            o_mode     <= fpc_pkg::FPC_MANUAL;
            run_req_q  <= 1'b0;
            stop_now_q <= 1'b0;
        end
        else if (prs[7])
        begin
            o_mode     <= fpc_pkg::FPC_AUTO;
            stop_now_q <= 1'b0;
        end
        else if (prs[6])
        begin
            if (o_mode == fpc_pkg::FPC_MANUAL && run_req_q)
                stop_now_q <= 1'b1;
            else if (o_mode == fpc_pkg::FPC_OFF)
                stop_now_q <= 1'b1;
            o_mode    <= fpc_pkg::FPC_OFF;
            run_req_q <= 1'b0;
        end
        else if (prs[8] && o_mode == fpc_pkg::FPC_MANUAL)
            run_req_q <= 1'b1;
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_engine_run <= 1'b0;
            o_gen_load   <= 1'b0;
            o_cooldown   <= 1'b0;
        end
        else
        begin
            unique case (o_mode)
                fpc_pkg::FPC_TEST:
                begin
                    o_engine_run <= 1'b1;
                    o_gen_load   <= 1'b1;
                    o_cooldown   <= 1'b0;
                end
                fpc_pkg::FPC_MANUAL:
                begin
                    o_engine_run <= run_req_q;
                    o_gen_load   <= 1'b0;
                    o_cooldown   <= 1'b0;
                end
                fpc_pkg::FPC_AUTO:
                begin
                    o_engine_run <= i_start_demand;
                    o_gen_load   <= i_start_demand;
                    o_cooldown   <= 1'b0;
                end
                default:
                begin
                    o_gen_load   <= 1'b0;
                    o_cooldown   <= o_engine_run && !stop_now_q;
                    if (stop_now_q)
                        o_engine_run <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // contactors and alarm relay
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_mains_ctc <= 1'b0;
            o_gen_ctc   <= 1'b0;
        end
        else if (o_mode == fpc_pkg::FPC_MANUAL && run_req_q)
        begin
            if (prs[1])
                o_mains_ctc <= !o_mains_ctc;
            if (prs[0])
                o_gen_ctc <= !o_gen_ctc;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_alarm_relay <= 1'b0;
            fault_q       <= 1'b0;
        end
        else
        begin
            fault_q <= i_fault;
            if (i_fault && !fault_q)
                o_alarm_relay <= 1'b1;
            else if (prs[4])
                o_alarm_relay <= 1'b0;
        end
    end

    // ========================================================
    // special modes
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_program_mode     <= 1'b0;
            o_service_clear    <= 1'b0;
            o_hand_tuning_mode <= 1'b0;
            o_tuning_group     <= 2'h0;
            o_annunc_mode      <= 1'b1;
            o_self_tuning_mode <= 1'b0;
        end
        else
        begin
            o_service_clear <= fire_serv;
            if (fire_prog)
                o_program_mode <= 1'b1;
            if (fire_adj)
                o_hand_tuning_mode <= 1'b1;
            if (fire_loop && o_hand_tuning_mode)
                o_tuning_group <= o_tuning_group + 2'h1;
            if (fire_ann && i_annunc_enable)
                o_annunc_mode <= 1'b0;
            if (fire_self && o_mode == fpc_pkg::FPC_MANUAL)
                o_self_tuning_mode <= 1'b1;
        end
    end

    // ========================================================
    // display navigation and scrolling
    assign last_scr = (i_screens_in_grp == 4'h0) ? 4'h0
                                                 : i_screens_in_grp - 4'h1;
    assign o_lamp_test = i_btn_next_scr;

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            susp_q <= 33'h0;
            tick_q <= 32'h0;
            secs_q <= 8'h0;
        end
        else
        begin
            if (any_press)
                susp_q <= 33'(SUSP_CYC);
            else if (susp_q != 33'h0)
                susp_q <= susp_q - 33'h1;
            if (tick_q == TICK_CYC - 32'd1)
            begin
                tick_q <= 32'h0;
                secs_q <= (secs_q + 8'h1 >= i_scroll_secs) ? 8'h0
                                                           : secs_q + 8'h1;
            end
            else
                tick_q <= tick_q + 32'h1;
            if (any_press || i_scroll_secs == 8'h0)
            begin
                tick_q <= 32'h0;
                secs_q <= 8'h0;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_group  <= fpc_pkg::GROUP_RST;
            o_screen <= fpc_pkg::SCREEN_RST;
        end
        else if (i_fault && !fault_q)
        begin
            o_group  <= fpc_pkg::ALARM_GROUP;
            o_screen <= fpc_pkg::SCREEN_RST;
        end
        else if (prs[3])
        begin
            o_screen <= fpc_pkg::SCREEN_RST;
            o_group  <= (o_group == 4'(NUM_GROUPS - 1)) ? 4'h0
                                                        : o_group + 4'h1;
        end
        else if (prs[2])
        begin
            o_screen <= fpc_pkg::SCREEN_RST;
            o_group  <= (o_group == 4'h0) ? 4'(NUM_GROUPS - 1)
                                          : o_group - 4'h1;
        end
        else if (prs[5] || (i_scroll_secs != 8'h0 && susp_q == 33'h0 &&
                 tick_q == TICK_CYC - 32'd1 &&
                 secs_q + 8'h1 >= i_scroll_secs))
            o_screen <= (o_screen >= last_scr) ? 4'h0
                                               : o_screen + 4'h1;
        else if (prs[4])
            o_screen <= (o_screen == 4'h0) ? last_scr
                                           : o_screen - 4'h1;
    end

    // ========================================================
    // lamps
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_led_auto_ready  <= 1'b0;
            o_led_alarm       <= 1'b0;
            o_led_mains_avail <= 1'b0;
        end
        else
        begin
            o_led_auto_ready <= i_btn_next_scr ||
                (o_mode == fpc_pkg::FPC_AUTO && !i_start_blocked);
            o_led_alarm <= i_btn_next_scr || i_shutdown_alarm ||
                           i_load_dump;
            if (i_btn_next_scr)
                o_led_mains_avail <= 1'b1;
            else if (i_mains_absence_override)
                o_led_mains_avail <= 1'b0;
            else if (i_simulate_mains)
                o_led_mains_avail <= 1'b1;
            else if (i_remote_start_cfg)
                o_led_mains_avail <= !i_remote_start;
            else
                o_led_mains_avail <= i_mains_ok;
        end
    end

endmodule

// *** sim/fpc_operator.sv ***
// Purpose: operator model pressing and holding front-panel buttons
// Assumes: one press or hold at a time, launched from a rising edge
// Notes: buttons always return to released between operations
`timescale 1ns/1ns
module fpc_operator
(
    input  wire logic   i_mclk,
    output logic [10:0] o_btn,
    output logic [5:0]  o_hold
);
    initial
    begin
        o_btn  = 11'h000;
        o_hold = 6'h00;
    end

    // ========================================================
    // short press: high for exactly one sampled edge
    task automatic press(input int b);
        @(posedge i_mclk);
        o_btn <= 11'h001 << b;
        @(posedge i_mclk);
        o_btn <= 11'h000;
    endtask

    // ========================================================
    // long press: high for n sampled edges
    task automatic hold(input int h, input int n);
        @(posedge i_mclk);
        o_hold <= 6'h01 << h;
        repeat (n) @(posedge i_mclk);
        o_hold <= 6'h00;
    endtask
endmodule

// *** sim/fpc_front_panel_asserts.sv ***
// Purpose: port-level checks of the front-panel block
// Assumes: single clock domain, async active-high reset
// Notes: hold count bounds allow two cycles of detector latency
`timescale 1ns/1ns
module fpc_front_panel_asserts
#(
    parameter int unsigned LONG_CYC   = 20,
    parameter int unsigned NUM_GROUPS = 12
)
(
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_btn_test,
    input wire logic       i_btn_manual,
    input wire logic       i_btn_auto,
    input wire logic       i_btn_off,
    input wire logic       i_btn_next_scr,
    input wire logic       i_btn_prev_scr,
    input wire logic       i_btn_next_grp,
    input wire logic       i_btn_prev_grp,
    input wire logic       i_combo_program,
    input wire logic       i_fault,
    input wire logic       i_shutdown_alarm,
    input wire logic       i_load_dump,
    input wire logic       i_simulate_mains,
    input wire logic       i_mains_absence_override,
    input wire logic [2:0] o_mode,
    input wire logic       o_engine_run,
    input wire logic       o_alarm_relay,
    input wire logic       o_program_mode,
    input wire logic       o_self_tuning_mode,
    input wire logic [3:0] o_group,
    input wire logic       o_led_alarm,
    input wire logic       o_led_mains_avail
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // ========================================================
    // consecutive hold count of the program combination
    logic [7:0] held_q;
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            held_q <= 8'h00;
        else if (!i_combo_program)
            held_q <= 8'h00;
        else if (held_q != 8'hff)
            held_q <= held_q + 8'h01;
    end

    // ========================================================
    // properties
    sequence s_man_off;
        o_mode == 3'b001 && o_engine_run && $rose(i_btn_off)
            && !i_btn_test && !i_btn_manual && !i_btn_auto;
    endsequence
    sequence s_stop;
        o_mode == 3'b000 ##1 !o_engine_run;
    endsequence
    property p_off_now;
        s_man_off |=> s_stop;
    endproperty
    property p_test;
        $rose(i_btn_test) |=> o_mode == 3'b011;
    endproperty
    property p_manual;
        $rose(i_btn_manual) && !i_btn_test |=> o_mode == 3'b001;
    endproperty
    property p_lamp_test;
        i_btn_next_scr |=> o_led_alarm && o_led_mains_avail;
    endproperty
    property p_alarm_lamp;
        !i_btn_next_scr |=>
            o_led_alarm == $past(i_shutdown_alarm || i_load_dump);
    endproperty
    property p_override;
        i_mains_absence_override && !i_btn_next_scr |=> !o_led_mains_avail;
    endproperty
    property p_simulate;
        i_simulate_mains && !i_mains_absence_override |=> o_led_mains_avail;
    endproperty
    property p_fault;
        $rose(i_fault) |=> o_group == fpc_pkg::ALARM_GROUP && o_alarm_relay;
    endproperty
    property p_relay_reset;
        $rose(i_btn_prev_scr) && !$rose(i_fault) |=> !o_alarm_relay;
    endproperty
    property p_grp_wrap;
        $rose(i_btn_next_grp) && !$rose(i_fault)
            && o_group == 4'(NUM_GROUPS - 1) |=> o_group == 4'h0;
    endproperty
    property p_grp_back;
        $rose(i_btn_prev_grp) && !i_btn_next_grp && !$rose(i_fault)
            && o_group == 4'h0 |=> o_group == 4'(NUM_GROUPS - 1);
    endproperty
    property p_prog_early;
        $rose(o_program_mode) |-> $past(held_q, 2) >= 8'(LONG_CYC - 1);
    endproperty
    property p_prog_late;
        held_q == 8'(LONG_CYC + 3) |-> o_program_mode;
    endproperty
    property p_selftune;
        $rose(o_self_tuning_mode) |-> $past(o_mode) == 3'b001;
    endproperty

    a_off_now:     assert property (p_off_now)     else $error("no stop");
    a_test:        assert property (p_test)        else $error("no test");
    a_manual:      assert property (p_manual)      else $error("no man");
    a_lamp_test:   assert property (p_lamp_test)   else $error("lamps");
    a_alarm_lamp:  assert property (p_alarm_lamp)  else $error("alarm");
    a_override:    assert property (p_override)    else $error("ovr");
    a_simulate:    assert property (p_simulate)    else $error("sim");
    a_fault:       assert property (p_fault)       else $error("fault");
    a_relay_reset: assert property (p_relay_reset) else $error("rly");
    a_grp_wrap:    assert property (p_grp_wrap)    else $error("wrap");
    a_grp_back:    assert property (p_grp_back)    else $error("back");
    a_prog_early:  assert property (p_prog_early)  else $error("early");
    a_prog_late:   assert property (p_prog_late)   else $error("late");
    a_selftune:    assert property (p_selftune)    else $error("tune");
endmodule

bind fpc_front_panel fpc_front_panel_asserts
    #(.LONG_CYC(LONG_CYC), .NUM_GROUPS(NUM_GROUPS)) chk_u (.*);

// *** sim/test_front_panel_mode_display_control.sv ***
// Purpose: self-checking bench of the front-panel block
// Assumes: shortened hold, suspend and tick counts
// Notes: expectations queued by the driver, checked on falling edges
`timescale 1ns/1ns
module test_front_panel_mode_display_control;
    localparam int LG = 20;
    localparam int SH = 8;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1;
    logic [10:0] pl = 11'h010;
    logic [7:0] scr_s = 8'h00;
    logic [3:0] nscr = 4'h4;
    logic [10:0] btn;
    logic [5:0] hl;
    logic [2:0] o_mode;
    logic [1:0] tg;
    logic [3:0] grp, scr, n;
    logic run, ld, cd, mc, gc, rly, pm, sc, ht, an, st, lt, ar, la, ma;
    logic [8:0] q[$];
    logic [8:0] e;
    int err_total = 0, comparisons = 0, svc = 0;
    always #10 i_mclk = ~i_mclk;

    fpc_operator op_u (.i_mclk(i_mclk), .o_btn(btn), .o_hold(hl));
    fpc_front_panel #(.LONG_CYC(LG), .SHORT_CYC(SH), .SUSP_CYC(50),
        .TICK_CYC(4), .NUM_GROUPS(12)) dut_u
    (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_btn_test(btn[0]),
        .i_btn_manual(btn[1]), .i_btn_run(btn[2]), .i_btn_auto(btn[3]),
        .i_btn_off(btn[4]), .i_btn_next_scr(btn[5]),
        .i_btn_prev_scr(btn[6]), .i_btn_next_grp(btn[7]),
        .i_btn_prev_grp(btn[8]), .i_btn_mains_ctc(btn[9]),
        .i_btn_gen_ctc(btn[10]), .i_combo_program(hl[0]),
        .i_combo_service(hl[1]), .i_combo_adjust(hl[2]),
        .i_hold_loop_grp(hl[3]), .i_hold_annunc(hl[4]),
        .i_hold_selftune(hl[5]), .i_annunc_enable(pl[10]),
        .i_scroll_secs(scr_s), .i_screens_in_grp(nscr), .i_fault(pl[0]),
        .i_start_blocked(pl[1]), .i_shutdown_alarm(pl[2]),
        .i_load_dump(pl[3]), .i_mains_ok(pl[4]),
        .i_remote_start_cfg(pl[5]), .i_remote_start(pl[6]),
        .i_simulate_mains(pl[7]), .i_mains_absence_override(pl[8]),
        .i_start_demand(pl[9]), .o_mode(o_mode), .o_engine_run(run),
        .o_gen_load(ld), .o_cooldown(cd), .o_mains_ctc(mc), .o_gen_ctc(gc),
        .o_alarm_relay(rly), .o_program_mode(pm), .o_service_clear(sc),
        .o_hand_tuning_mode(ht), .o_tuning_group(tg), .o_annunc_mode(an),
        .o_self_tuning_mode(st), .o_group(grp), .o_screen(scr),
        .o_lamp_test(lt), .o_led_auto_ready(ar), .o_led_alarm(la),
        .o_led_mains_avail(ma)
    );

    // ========================================================
    // observation, comparison and queue
    function automatic logic [3:0] obs(input logic [4:0] s);
        case (s)
            5'h00:   obs = {1'b0, o_mode};
            5'h01:   obs = {3'h0, run};
            5'h02:   obs = {3'h0, ld};
            5'h03:   obs = {3'h0, cd};
            5'h04:   obs = {2'h0, gc, mc};
            5'h05:   obs = {3'h0, rly};
            5'h06:   obs = {1'b0, st, ht, pm};
            5'h07:   obs = {2'h0, tg};
            5'h08:   obs = {3'h0, an};
            5'h09:   obs = grp;
            5'h0a:   obs = scr;
            5'h0b:   obs = {2'h0, ma, ar};
            5'h0d:   obs = {2'h0, la, lt};
            default: obs = 4'(svc);
        endcase
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic chk(input logic [4:0] s, input logic [3:0] x);
        q.push_back({s, x});
    endtask
    always @(negedge i_mclk)
        while (q.size() > 0)
        begin
            e = q.pop_front();
            check(obs(e[8:4]), e[3:0]);
        end
    always @(negedge i_mclk)
        if (sc === 1'b1)
            svc++;
    task automatic stp(input int k);
        repeat (k) @(posedge i_mclk);
    endtask
    task automatic summarize;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        stp(100000);
        err_total++;
        summarize;
    end

    // ========================================================
    // scenarios
    initial
    begin
        void'($urandom(32'h34f7cd08));
        stp(20);
        i_sys_rst <= 1'b0;
        op_u.press(2); stp(3); chk(1, 0);
        op_u.press(1); chk(0, 1);
        op_u.press(2); stp(2); chk(1, 1); chk(2, 0);
        op_u.press(9); chk(4, 1);
        op_u.press(10); chk(4, 3);
        op_u.press(9); chk(4, 2);
        op_u.press(4); chk(0, 0); stp(2); chk(1, 0);
        op_u.press(0); chk(0, 3); stp(2); chk(1, 1); chk(2, 1);
        op_u.press(4); chk(0, 0); stp(2); chk(3, 1); chk(1, 1);
        op_u.press(4); stp(2); chk(1, 0);
        op_u.press(3); stp(2); chk(0, 2); chk(1, 0); chk(11, 3);
        pl[9] <= 1'b1; stp(3); chk(1, 1); chk(2, 1);
        pl[1] <= 1'b1; stp(2); chk(11, 2);
        pl <= 11'h010; op_u.press(4); op_u.press(4);
        $display("test modes done");
        for (int i = 1; i <= 12; i++)
        begin
            op_u.press(7); chk(9, 4'(i % 12));
        end
        op_u.press(8); chk(9, 11);
        n = 4'(2 + $urandom % 14);
        nscr <= n; op_u.press(7); chk(9, 0);
        op_u.press(6); chk(10, n - 1);
        op_u.press(5); chk(10, 0);
        pl[0] <= 1'b1; stp(2); chk(9, 8); chk(10, 0); chk(5, 1);
        op_u.press(6); chk(5, 0); chk(10, n - 1);
        pl[0] <= 1'b0;
        $display("test display done");
        op_u.hold(0, LG - 4); op_u.hold(0, LG - 4); stp(2); chk(6, 0);
        op_u.hold(0, LG + 3); stp(2); chk(6, 1);
        op_u.hold(1, LG - 4); op_u.hold(1, LG + 3); stp(2); chk(16, 1);
        op_u.hold(3, SH + 3); stp(2); chk(7, 0);
        op_u.hold(2, LG + 3); stp(2); chk(6, 3);
        op_u.hold(3, SH + 3); stp(2); chk(7, 1);
        op_u.hold(4, LG + 3); stp(2); chk(8, 1);
        pl[10] <= 1'b1; op_u.hold(4, LG + 3); stp(2); chk(8, 0);
        op_u.hold(5, LG + 3); stp(2); chk(6, 3);
        op_u.press(1); op_u.hold(5, LG + 3); stp(2); chk(6, 7);
        op_u.press(4);
        $display("test holds done");
        scr_s <= 8'(1 + $urandom % 2);
        fork
            op_u.press(5);
            begin
                @(posedge i_mclk);
                chk(13, 1);
            end
        join
        chk(10, 0); chk(13, 2);
        stp(40); chk(10, 0);
        for (int i = 0; i < 80 && scr !== 4'h1; i++)
            stp(1);
        chk(10, 1);
        scr_s <= 8'h00; op_u.press(5); stp(120); chk(10, 4'(2 % n));
        $display("test scroll done");
        for (int i = 0; i < 40; i++)
        begin
            @(posedge i_mclk);
            pl <= 11'($urandom);
        end
        stp(1); pl[8] <= 1'b1; stp(2); chk(11, {1'b0, 1'b0});
        pl[8:7] <= 2'b01; stp(2); chk(12, 1); chk(11, 2);
        pl[8:5] <= 4'b0011; pl[3:2] <= 2'b01; stp(2); chk(11, 0);
        chk(13, 2);
        $display("test lamps done");
        stp(2);
        summarize;
    end
endmodule
